//--- design/sdfem_regs.vh
`ifndef SDFEM_REGS_VH
`define SDFEM_REGS_VH

// ----------------------------------------
// operation class codes from the decoder
// ----------------------------------------
`define SDFEM_OP_W               6
`define SDFEM_OP_PACKED_ADD      6'h00
`define SDFEM_OP_SCALAR_ADD      6'h01
`define SDFEM_OP_PACKED_AND      6'h02
`define SDFEM_OP_PACKED_AND_NOT  6'h03
`define SDFEM_OP_PACKED_OR       6'h04
`define SDFEM_OP_PACKED_CMP      6'h05
`define SDFEM_OP_SCALAR_CMP      6'h06
`define SDFEM_OP_ORD_CMP_FLAGS   6'h07
`define SDFEM_OP_INT_TO_SINGLE   6'h08
`define SDFEM_OP_SINGLE_TO_INT_R 6'h09
`define SDFEM_OP_SINGLE_TO_INT_T 6'h0a
`define SDFEM_OP_INT_TO_DOUBLE   6'h0b
`define SDFEM_OP_DOUBLE_TO_INT_R 6'h0c
`define SDFEM_OP_DBL_LEG_INT_R   6'h0d
`define SDFEM_OP_DBL_TO_SINGLE   6'h0e
`define SDFEM_OP_LEG_INT_TO_DBL  6'h0f
`define SDFEM_OP_SINGLE_TO_DBL   6'h10
`define SDFEM_OP_SD_TO_GPR_R     6'h11
`define SDFEM_OP_SD_TO_SINGLE    6'h12
`define SDFEM_OP_GPR_TO_SD       6'h13
`define SDFEM_OP_SS_TO_DBL       6'h14
`define SDFEM_OP_DOUBLE_TO_INT_T 6'h15
`define SDFEM_OP_DBL_LEG_INT_T   6'h16
`define SDFEM_OP_SD_TO_GPR_T     6'h17
`define SDFEM_OP_PACKED_DIV      6'h18
`define SDFEM_OP_SCALAR_DIV      6'h19
`define SDFEM_OP_PACKED_MAX      6'h1a
`define SDFEM_OP_SCALAR_MAX      6'h1b
`define SDFEM_OP_PACKED_MIN      6'h1c
`define SDFEM_OP_SCALAR_MIN      6'h1d
`define SDFEM_OP_ALIGNED_MOVE    6'h1e
`define SDFEM_OP_UPPER_MOVE      6'h1f
`define SDFEM_OP_LOWER_MOVE      6'h20
`define SDFEM_OP_SIGN_MASK       6'h21
`define SDFEM_OP_SCALAR_MOVE     6'h22
`define SDFEM_OP_UNALIGNED_MOVE  6'h23
`define SDFEM_OP_PACKED_MUL      6'h24
`define SDFEM_OP_SCALAR_MUL      6'h25
`define SDFEM_OP_SHUFFLE         6'h26
`define SDFEM_OP_PACKED_ROOT     6'h27
`define SDFEM_OP_SCALAR_ROOT     6'h28

// ----------------------------------------
// enable vector: invalid denormal zdiv overflow underflow precision
// ----------------------------------------
`define SDFEM_EXC_W     6
`define SDFEM_BIT_INV   5
`define SDFEM_BIT_DEN   4
`define SDFEM_BIT_ZDIV  3
`define SDFEM_BIT_OVF   2
`define SDFEM_BIT_UNF   1
`define SDFEM_BIT_PREC  0
`define SDFEM_EN_NONE   6'h00
`define SDFEM_EN_ARITH  6'h37
`define SDFEM_EN_ALL    6'h3f
`define SDFEM_EN_ID     6'h30
`define SDFEM_EN_IP     6'h21
`define SDFEM_EN_P      6'h01
`define SDFEM_EN_IDP    6'h31

// ----------------------------------------
// rounding control
// ----------------------------------------
`define SDFEM_RND_W     2
`define SDFEM_RND_ZERO  2'h3
`define SDFEM_RND_NEAR  2'h0

`endif

//--- design/sdfem_class.v
`include "sdfem_regs.vh"

module sdfem_class (
    input  wire [`SDFEM_OP_W-1:0]  op_class,
    output reg  [`SDFEM_EXC_W-1:0] enable_vec,
    output reg                     op_known,
    output reg                     uses_rounding,
    output reg                     truncating
);

    // ----------------------------------------
    // per-class permitted conditions
    // ----------------------------------------
    always @* begin
        enable_vec    = `SDFEM_EN_NONE;
        op_known      = 1'b1;
        uses_rounding = 1'b0;
        truncating    = 1'b0;
        case (op_class)
            `SDFEM_OP_PACKED_ADD, `SDFEM_OP_SCALAR_ADD: begin
                enable_vec = `SDFEM_EN_ARITH;
            end
            `SDFEM_OP_PACKED_AND, `SDFEM_OP_PACKED_AND_NOT, `SDFEM_OP_PACKED_OR: begin
                enable_vec = `SDFEM_EN_NONE;
            end
            `SDFEM_OP_PACKED_CMP, `SDFEM_OP_SCALAR_CMP: begin
                enable_vec = `SDFEM_EN_ID;
            end
            `SDFEM_OP_ORD_CMP_FLAGS: begin
                enable_vec = `SDFEM_EN_ID;
            end
            `SDFEM_OP_INT_TO_SINGLE: begin
                enable_vec    = `SDFEM_EN_P;
                uses_rounding = 1'b1;
            end
            `SDFEM_OP_SINGLE_TO_INT_R: begin
                enable_vec    = `SDFEM_EN_IP;
                uses_rounding = 1'b1;
            end
            `SDFEM_OP_SINGLE_TO_INT_T: begin
                enable_vec = `SDFEM_EN_IP;
                truncating = 1'b1;
            end
            `SDFEM_OP_INT_TO_DOUBLE, `SDFEM_OP_LEG_INT_TO_DBL, `SDFEM_OP_GPR_TO_SD: begin
                enable_vec    = `SDFEM_EN_NONE;
                uses_rounding = 1'b1;
            end
            `SDFEM_OP_DOUBLE_TO_INT_R, `SDFEM_OP_DBL_LEG_INT_R, `SDFEM_OP_SD_TO_GPR_R: begin
                enable_vec    = `SDFEM_EN_IP;
                uses_rounding = 1'b1;
            end
            `SDFEM_OP_DOUBLE_TO_INT_T, `SDFEM_OP_DBL_LEG_INT_T, `SDFEM_OP_SD_TO_GPR_T: begin
                enable_vec = `SDFEM_EN_IP;
                truncating = 1'b1;
            end
            `SDFEM_OP_DBL_TO_SINGLE, `SDFEM_OP_SD_TO_SINGLE: begin
                enable_vec    = `SDFEM_EN_ARITH;
                uses_rounding = 1'b1;
            end
            `SDFEM_OP_SINGLE_TO_DBL, `SDFEM_OP_SS_TO_DBL: begin
                enable_vec = `SDFEM_EN_ID;
            end
            `SDFEM_OP_PACKED_DIV, `SDFEM_OP_SCALAR_DIV: begin
                enable_vec    = `SDFEM_EN_ALL;
                uses_rounding = 1'b1;
            end
            `SDFEM_OP_PACKED_MAX, `SDFEM_OP_SCALAR_MAX, `SDFEM_OP_PACKED_MIN, `SDFEM_OP_SCALAR_MIN: begin
                enable_vec = `SDFEM_EN_ID;
            end
            `SDFEM_OP_ALIGNED_MOVE, `SDFEM_OP_UNALIGNED_MOVE, `SDFEM_OP_UPPER_MOVE,
            `SDFEM_OP_LOWER_MOVE, `SDFEM_OP_SCALAR_MOVE, `SDFEM_OP_SIGN_MASK,
            `SDFEM_OP_SHUFFLE: begin
                enable_vec = `SDFEM_EN_NONE;
            end
            `SDFEM_OP_PACKED_MUL, `SDFEM_OP_SCALAR_MUL: begin
                enable_vec    = `SDFEM_EN_ARITH;
                uses_rounding = 1'b1;
            end
            `SDFEM_OP_PACKED_ROOT, `SDFEM_OP_SCALAR_ROOT: begin
                enable_vec    = `SDFEM_EN_IDP;
                uses_rounding = 1'b1;
            end
            default: begin
                enable_vec = `SDFEM_EN_NONE;
                op_known   = 1'b0;
            end
        endcase
    end

endmodule

//--- design/sdfem_exception_map.v
// How it works
// - double add: all but divide-by-zero
// - bitwise and, and-not, or: none
// - predicate compares: invalid and denormal only
// - ordered flag compare: invalid, denormal only
// - int to single: precision only
// - single to int: invalid, precision only
// - int to double conversions: none
// - double to int conversions: invalid, precision
// - double to single: all but divide-by-zero
// - single to double: invalid, denormal only
// - double divide: all six conditions
// - maximum and minimum: invalid, denormal only
// - moves, sign mask, shuffle: none
// - double multiply: all but divide-by-zero
// - square root: invalid, denormal, precision
// - truncating rounds to zero, other rounding classes use control, the rest nearest
`include "sdfem_regs.vh"

module sdfem_exception_map (
    input  wire                     core_clk,
    input  wire                     rst,
    input  wire                     op_valid,
    input  wire [`SDFEM_OP_W-1:0]   op_class,
    input  wire [`SDFEM_RND_W-1:0]  ctrl_round_mode,
    input  wire                     det_valid,
    input  wire [`SDFEM_EXC_W-1:0]  det_raw,
    output reg                      enable_valid_q,
    output reg  [`SDFEM_EXC_W-1:0]  enable_vec_q,
    output reg  [`SDFEM_RND_W-1:0]  round_mode_q,
    output reg                      op_unknown_q,
    output reg                      raised_valid_q,
    output reg  [`SDFEM_EXC_W-1:0]  raised_q
);

    // ----------------------------------------
    // class decode
    // ----------------------------------------
    wire [`SDFEM_EXC_W-1:0] cls_enable;
    wire                    cls_known;
    wire                    cls_round;
    wire                    cls_trunc;

    sdfem_class u_class (
        .op_class      (op_class),
        .enable_vec    (cls_enable),
        .op_known      (cls_known),
        .uses_rounding (cls_round),
        .truncating    (cls_trunc)
    );

    reg [`SDFEM_RND_W-1:0]  round_mode_d;
    reg [`SDFEM_EXC_W-1:0]  held_enable_q;
    reg [`SDFEM_EXC_W-1:0]  gate_vec;

    always @* begin
        if (cls_trunc) begin
            round_mode_d = `SDFEM_RND_ZERO;
        end else if (cls_round) begin
            round_mode_d = ctrl_round_mode;
        end else begin
            round_mode_d = `SDFEM_RND_NEAR;
        end
    end

    // ----------------------------------------
    // detected conditions see the enable of the current op
    // ----------------------------------------
    always @* begin
        if (op_valid) begin
            gate_vec = cls_enable;
        end else begin
            gate_vec = held_enable_q;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            enable_valid_q <= 1'b0;
            enable_vec_q   <= `SDFEM_EN_NONE;
            round_mode_q   <= `SDFEM_RND_NEAR;
            op_unknown_q   <= 1'b0;
            held_enable_q  <= `SDFEM_EN_NONE;
            raised_valid_q <= 1'b0;
            raised_q       <= `SDFEM_EN_NONE;
        end else begin
            enable_valid_q <= op_valid;
            raised_valid_q <= det_valid;
            if (op_valid) begin
                enable_vec_q  <= cls_enable;
                held_enable_q <= cls_enable;
                round_mode_q  <= round_mode_d;
                op_unknown_q  <= ~cls_known;
            end
            if (det_valid) begin
                raised_q <= det_raw & gate_vec;
            end else begin
                raised_q <= `SDFEM_EN_NONE;
            end
        end
    end

endmodule

//--- bench/sdfem_checker.sv
module sdfem_checker (
    input wire       core_clk,
    input wire       rst,
    input wire       op_valid,
    input wire [5:0] op_class,
    input wire [1:0] ctrl_round_mode,
    input wire       det_valid,
    input wire [5:0] det_raw,
    input wire       enable_valid_q,
    input wire [5:0] enable_vec_q,
    input wire [1:0] round_mode_q,
    input wire       op_unknown_q,
    input wire       raised_valid_q,
    input wire [5:0] raised_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    op_ack_a: assert property (op_valid |=> enable_valid_q) else $error("op not answered");
    det_quiet_a: assert property (!det_valid |=> !raised_valid_q && raised_q == 6'h00) else $error("raised w/o det");
    raised_gated_a: assert property ((raised_q & ~enable_vec_q) == 6'h00) else $error("raised not enabled");
    det_pass_a: assert property (det_valid && !op_valid |=> raised_q == ($past(det_raw) & $past(enable_vec_q)))
        else $error("det gating wrong");
    arith_vec_a: assert property (op_valid && op_class inside {6'h00, 6'h01, 6'h0e, 6'h12, 6'h24, 6'h25}
        |=> enable_vec_q == 6'h37) else $error("arith vector wrong");
    cmp_vec_a: assert property (op_valid && op_class inside {[6'h05:6'h07], 6'h10, 6'h14, [6'h1a:6'h1d]}
        |=> enable_vec_q == 6'h30) else $error("compare vector wrong");
    no_exc_a: assert property (op_valid && op_class inside {[6'h02:6'h04], 6'h0b, 6'h0f, 6'h13, [6'h1e:6'h23], 6'h26}
        |=> enable_vec_q == 6'h00 && !op_unknown_q) else $error("quiet op vector wrong");
    to_int_a: assert property (op_valid && op_class inside {6'h09, 6'h0a, 6'h0c, 6'h0d, 6'h11, [6'h15:6'h17]}
        |=> enable_vec_q == 6'h21) else $error("to int vector wrong");
    div_all_a: assert property (op_valid && op_class inside {6'h18, 6'h19} |=> enable_vec_q == 6'h3f)
        else $error("divide vector wrong");
    prec_root_a: assert property (op_valid && op_class inside {6'h08, 6'h27, 6'h28}
        |=> enable_vec_q == ($past(op_class) == 6'h08 ? 6'h01 : 6'h31)) else $error("root vector wrong");
    trunc_rnd_a: assert property (op_valid && op_class inside {6'h0a, [6'h15:6'h17]} |=> round_mode_q == 2'h3)
        else $error("truncate not to zero");
    ctrl_rnd_a: assert property (op_valid && op_class inside {[6'h09:6'h0d], 6'h0f, 6'h11, 6'h13} && op_class != 6'h0a
        |=> round_mode_q == $past(ctrl_round_mode)) else $error("control rounding lost");
endmodule

bind sdfem_exception_map sdfem_checker sdfem_checker_inst (.*);

//--- bench/sdfem_dp_model.sv
module sdfem_dp_model (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       op_valid,
    output reg        det_valid,
    output reg  [5:0] det_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    // worst-case datapath: every op reports all six conditions a cycle later
    always @(posedge core_clk) begin
        det_valid <= !rst && op_valid;
        // idle raw lines scramble rather than hold
        det_raw   <= rst ? 6'h2a : (op_valid ? 6'h3f : ~det_raw);
    end
endmodule

//--- bench/test_sdfem_exception_map.sv
`include "sdfem_regs.vh"
module test_sdfem_exception_map;
    timeunit 1ns;
    timeprecision 1ps;
    reg        core_clk = 0, rst = 1, op_valid = 0;
    reg  [5:0] op_class = 6'h00, prv;
    reg  [1:0] ctrl_round_mode = 2'h0, prv_r;
    wire       det_valid, enable_valid_q, op_unknown_q, raised_valid_q;
    wire [5:0] det_raw, enable_vec_q, raised_q;
    wire [1:0] round_mode_q;
    int        errors = 0, n_tests = 0, i;
    sdfem_exception_map sdfem_exception_map_inst (.core_clk, .rst, .op_valid, .op_class, .ctrl_round_mode,
        .det_valid, .det_raw, .enable_valid_q, .enable_vec_q, .round_mode_q, .op_unknown_q, .raised_valid_q, .raised_q);
    sdfem_dp_model sdfem_dp_model_inst (.core_clk, .rst, .op_valid, .det_valid, .det_raw);
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    function [5:0] exp_vec(input [5:0] c);
        case (c)
            6'h00, 6'h01, 6'h0e, 6'h12, 6'h24, 6'h25: exp_vec = 6'h37;
            6'h05, 6'h06, 6'h07, 6'h10, 6'h14, 6'h1a, 6'h1b, 6'h1c, 6'h1d: exp_vec = 6'h30;
            6'h08: exp_vec = 6'h01;
            6'h09, 6'h0a, 6'h0c, 6'h0d, 6'h11, 6'h15, 6'h16, 6'h17: exp_vec = 6'h21;
            6'h18, 6'h19: exp_vec = 6'h3f;
            6'h27, 6'h28: exp_vec = 6'h31;
            default: exp_vec = 6'h00;
        endcase
    endfunction
    function [5:0] exp_rnd(input [5:0] c, input [1:0] r);
        case (c)
            6'h0a, 6'h15, 6'h16, 6'h17: exp_rnd = 6'h03;
            6'h09, 6'h0b, 6'h0c, 6'h0d, 6'h0f, 6'h11, 6'h13: exp_rnd = {4'h0, r};
            // int-to-single, narrowing, divide, multiply and root classes also follow the control field
            6'h08, 6'h0e, 6'h12, 6'h18, 6'h19, 6'h24, 6'h25, 6'h27, 6'h28: exp_rnd = {4'h0, r};
            default: exp_rnd = 6'h00;
        endcase
    endfunction
    task check(input [5:0] got, input [5:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task check_op(input [5:0] c, input [1:0] r, input bit had_det);
        check({5'h0, enable_valid_q}, 6'h01);
        check(enable_vec_q, exp_vec(c));
        check({4'h0, round_mode_q}, exp_rnd(c, r));
        check({5'h0, op_unknown_q}, {5'h0, c > 6'h28});
        check(raised_q, had_det ? exp_vec(c) : 6'h00);
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge core_clk);
        errors++;
        wrap_up;
    end
    initial begin
        repeat (16) @(posedge core_clk);
        #1 rst = 0;
        // every class back to back, then two unmapped codes
        for (i = 0; i < 43; i++) begin
            @(posedge core_clk);
            #1;
            if (i > 0) check_op(prv, prv_r, i > 1);
            prv = (i == 42) ? 6'h3f : i[5:0];
            prv_r = i[1:0];
            op_valid = 1;
            op_class = prv;
            ctrl_round_mode = prv_r;
        end
        @(posedge core_clk);
        #1 check_op(prv, prv_r, 1);
        op_valid = 0;
        op_class = 6'h18;
        @(posedge core_clk);
        #1 check(raised_q, 6'h00);
        op_valid = 1;
        rst = 1;
        @(posedge core_clk);
        #1 rst = 0;
        op_valid = 0;
        check(enable_vec_q, 6'h00);
        check({5'h0, enable_valid_q}, 6'h00);
        wrap_up;
    end
endmodule
